// file: urcp_top.sv
// Register command interpreter behind the bulk endpoints
//
// How it works
// [RULE_01] A command is two to five bytes, its length set by its address.
// [RULE_02] The first byte is the register address and picks the data count.
// [RULE_03] The host sends data bytes MSB first right after the address.
// [RULE_04] Read data is offered only after the command has fully executed.
// [RULE_05] Read data is valid only after a query register was written.
// [RULE_06] A query write loads its response for the host at once; the code loads it in URCP_DONE, after cmd_done.
// [RULE_07] Response bytes go out most significant byte first.
// [RULE_08] The host reads exactly the valid byte count of the query.
// [RULE_09] Five-byte host buffers hold any command or response.
// [RULE_10] Commands and responses travel as bulk transfers.
// [RULE_11] Bulk OUT/IN carry them and no transfer passes 64 bytes.
// [RULE_12] Data bytes after the address are counted before execution.

`timescale 1ns/1ps
`default_nettype none
`include "urcp_defines.svh"

module urcp_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,

    // Bulk OUT byte stream
    input wire urcp_pkg::urcp_byte_s out_byte,
    output logic out_ready,

    // Bulk IN byte stream
    output urcp_pkg::urcp_byte_s in_byte,
    input wire logic in_ready,

    // Register file side
    output urcp_pkg::urcp_cmd_s cmd,
    output logic cmd_valid,
    input wire logic cmd_done,
    input wire logic [31:0] query_data,

    // Status
    output logic resp_valid,
    output logic overrun
);

    // ==================================================================
    // State record
    typedef struct packed {
        // Command being parsed
        urcp_pkg::urcp_state_e st;
        logic [7:0] addr;
        logic [31:0] data;
        logic [2:0] need;
        logic [2:0] cnt;
        // Bytes seen in the current bulk OUT packet
        logic [6:0] xfer;
        // Response held for the host
        logic is_q;
        logic [31:0] resp;
        logic [2:0] rlen;
        logic [2:0] ridx;
        logic rvalid;
        // Byte streams
        logic out_rdy;
        urcp_pkg::urcp_byte_s ib;
        // Command handed over
        urcp_pkg::urcp_cmd_s c;
        logic cv;
        // Sticky packet overrun
        logic ovr;
    } urcp_regs_s;

    urcp_regs_s r;
    urcp_regs_s next_r;

    logic [2:0] lut_dlen;
    logic [2:0] lut_rlen;
    logic lut_q;

    logic take;
    logic [2:0] pos;
    logic resp_last;
    logic resp_offer;

    // ==================================================================
    // Length lookup on the address byte
    urcp_len_lut u_lut (
        .addr(out_byte.data),
        .data_len(lut_dlen),
        .resp_len(lut_rlen),
        .is_query(lut_q)
    );

    // ==================================================================
    // Handshake and response position
    assign take = out_byte.valid && r.out_rdy;
    assign pos = 3'(`URCP_RESP_FULL - 3'h1 - r.ridx);
    assign resp_last = (r.ridx == 3'(`URCP_RESP_FULL - 3'h1));
    assign resp_offer = !r.ib.valid && r.rvalid &&
                        (r.st == urcp_pkg::URCP_IDLE);

    // ==================================================================
    // Next state
    always_comb begin
        // Every field but cv and out_rdy holds unless changed below; cv clears and out_rdy follows the state
        next_r = r;
        next_r.cv = 1'b0;
        next_r.out_rdy = (r.st == urcp_pkg::URCP_IDLE) ||
                         (r.st == urcp_pkg::URCP_DATA);

        // Packet length guard
        if (take) begin
            if (r.xfer == `URCP_EP_MAX_BYTES) begin
                next_r.ovr = 1'b1; // see [RULE_11]
            end
            // Count restarts at packet end and stops past the limit
            if (out_byte.last) begin
                next_r.xfer = 7'h0;
            end else if (r.xfer <= `URCP_EP_MAX_BYTES) begin
                next_r.xfer = 7'(r.xfer + 7'h1);
            end
        end

        // Command parse and execution
        case (r.st)
            urcp_pkg::URCP_IDLE: begin
                // Address byte picks the data count
                if (take) begin
                    next_r.addr = out_byte.data; // see [RULE_02]
                    next_r.need = lut_dlen; // see [RULE_01]
                    next_r.is_q = lut_q;
                    next_r.rlen = lut_rlen;
                    next_r.cnt = 3'h0;
                    next_r.data = 32'h0;
                    next_r.st = urcp_pkg::URCP_DATA;
                end
            end

            urcp_pkg::URCP_DATA: begin
                // Data bytes, MSB first
                if (take) begin
                    next_r.data = {r.data[23:0], out_byte.data}; // see [RULE_03]
                    next_r.cnt = 3'(r.cnt + 3'h1);
                    if (3'(r.cnt + 3'h1) == r.need) begin
                        next_r.st = urcp_pkg::URCP_EXEC; // see [RULE_12]
                        next_r.out_rdy = 1'b0;
                    end
                end
            end

            urcp_pkg::URCP_EXEC: begin
                // Hand the command over, drop the old reply
                next_r.c.addr = r.addr;
                next_r.c.data = r.data;
                next_r.c.len = r.need;
                next_r.cv = 1'b1;
                next_r.rvalid = 1'b0;
                next_r.ib.valid = 1'b0;
                next_r.st = urcp_pkg::URCP_WAIT;
            end

            urcp_pkg::URCP_WAIT: begin
                // Wait for the register file
                if (cmd_done) begin
                    next_r.st = urcp_pkg::URCP_DONE;
                end
            end

            urcp_pkg::URCP_DONE: begin
                // Load the reply of a query
                if (r.is_q) begin
                    next_r.resp = query_data; // see [RULE_06]
                    next_r.rvalid = 1'b1; // see [RULE_05]
                    next_r.ridx = 3'(`URCP_RESP_FULL - r.rlen);
                end
                next_r.st = urcp_pkg::URCP_IDLE; // see [RULE_04]
            end

            default: begin
                next_r.st = urcp_pkg::URCP_IDLE;
            end
        endcase

        // Response drain, new bytes offered only between commands
        if (r.ib.valid && in_ready) begin
            // Byte taken by the host
            next_r.ib.valid = 1'b0; // see [RULE_10]
            next_r.ridx = 3'(r.ridx + 3'h1);
            if (r.ib.last) begin
                next_r.rvalid = 1'b0;
            end
        end else if (resp_offer) begin
            // Offer the next byte
            next_r.ib.valid = 1'b1;
            next_r.ib.data = r.resp[pos*8 +: 8]; // see [RULE_07]
            next_r.ib.last = resp_last;
        end
    end

    // ==================================================================
    // State register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ==================================================================
    // Outputs, all straight from the state record
    assign out_ready = r.out_rdy;
    assign in_byte = r.ib;
    assign cmd = r.c;
    assign cmd_valid = r.cv;

    // Status
    assign resp_valid = r.rvalid;
    assign overrun = r.ovr;

endmodule // urcp_top

`default_nettype wire

// file: urcp_defines.svh
// Constants for the register command port
`ifndef URCP_DEFINES_SVH
`define URCP_DEFINES_SVH

`define URCP_CMD_MAX_BYTES 3'h5
`define URCP_EP_MAX_BYTES 7'h40
`define URCP_ADDR_CURRENT_STATE 8'h19
`define URCP_ADDR_DEVICE_STATUS 8'h1a
`define URCP_ADDR_TEMPERATURE 8'h1b
`define URCP_ADDR_DEVICE_INFO 8'h1c
`define URCP_ADDR_SERIAL_OUT 8'h1d
`define URCP_RESP_FULL 3'h4
`define URCP_RESP_SHORT 3'h2
`define URCP_DATA_DEFAULT 3'h1
`define URCP_DATA_QUERY 3'h1
`define URCP_DATA_SERIAL_OUT 3'h4
`define URCP_ZERO_BYTE 8'h00

`endif

// file: urcp_pkg.sv
// Types for the register command port
package urcp_pkg;

    typedef enum logic [2:0] {
        URCP_IDLE = 3'b000,
        URCP_DATA = 3'b001,
        URCP_EXEC = 3'b010,
        URCP_WAIT = 3'b011,
        URCP_DONE = 3'b100
    } urcp_state_e;

    // Byte stream with handshake
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } urcp_byte_s;

    // Command handed to the register file
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [2:0] len;
    } urcp_cmd_s;

endpackage

// file: urcp_len_lut.sv
// Data length and response length per register address
`timescale 1ns/1ps
`default_nettype none
`include "urcp_defines.svh"

module urcp_len_lut (
    // Lookup
    input wire logic [7:0] addr,
    output logic [2:0] data_len,
    output logic [2:0] resp_len,
    output logic is_query
);

    always_comb begin
        data_len = `URCP_DATA_DEFAULT;
        resp_len = `URCP_RESP_FULL;
        is_query = 1'b0;
        if (addr == `URCP_ADDR_DEVICE_STATUS) begin
            data_len = `URCP_DATA_QUERY;
            resp_len = `URCP_RESP_SHORT;
            is_query = 1'b1;
        end else if (addr == `URCP_ADDR_CURRENT_STATE ||
                     addr == `URCP_ADDR_TEMPERATURE ||
                     addr == `URCP_ADDR_DEVICE_INFO) begin
            data_len = `URCP_DATA_QUERY;
            is_query = 1'b1;
        end else if (addr == `URCP_ADDR_SERIAL_OUT) begin
            data_len = `URCP_DATA_SERIAL_OUT;
        end
    end

endmodule // urcp_len_lut

`default_nettype wire

// file: urcp_asserts.sv
// Checker for the command port
`timescale 1ns/1ps
`default_nettype none
module urcp_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Watched ports
    input wire urcp_pkg::urcp_byte_s out_byte,
    input wire logic out_ready,
    input wire urcp_pkg::urcp_byte_s in_byte,
    input wire logic in_ready,
    input wire urcp_pkg::urcp_cmd_s cmd,
    input wire logic cmd_valid,
    input wire logic cmd_done,
    input wire logic [31:0] query_data,
    input wire logic resp_valid,
    input wire logic overrun
);
// ====
// Checks
default clocking @(posedge core_clk); endclocking
default disable iff (!reset_n);
chk_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("cmd pulse");
chk_busy_exec: assert property (cmd_valid |-> !out_ready
    && $past(!out_ready))
    else $error("busy");
chk_resp_late: assert property ($rose(resp_valid) |->
    $past(cmd_done, 2))
    else $error("early resp");
chk_resp_load: assert property (cmd_done &&
    cmd.addr == 8'h1a |-> ##2 resp_valid)
    else $error("no resp");
chk_only_query: assert property ($rose(in_byte.valid) |->
    resp_valid)
    else $error("stray data");
chk_msb_first: assert property ($rose(resp_valid) &&
    cmd.addr == 8'h1a |=> in_byte.valid && in_byte.data == query_data[15:8])
    else $error("msb");
chk_in_hold: assert property (in_byte.valid && !in_ready |=>
    $stable(in_byte))
    else $error("in hold");
chk_overrun_kept: assert property (overrun |=> overrun)
    else $error("overrun");
cover property ($rose(resp_valid) && cmd.addr == 8'h1a);
cover property (cmd_valid && cmd.addr == 8'h1d);
cover property (in_byte.valid && in_ready && in_byte.last);
cover property ($rose(overrun));
endmodule // urcp_asserts
bind urcp_top urcp_asserts i_chk (.core_clk, .reset_n, .out_byte, .out_ready,
    .in_byte, .in_ready, .cmd, .cmd_valid, .cmd_done, .query_data, .resp_valid,
    .overrun);
`default_nettype wire

// file: urcp_rf_model.sv
// Register file stand-in
`timescale 1ns/1ps
`default_nettype none
module urcp_rf_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Commands
    input wire urcp_pkg::urcp_cmd_s cmd,
    input wire logic cmd_valid,
    output logic cmd_done,
    output logic [31:0] query_data
);
// ====
// Answers fast and slow in turn
logic [2:0] cnt;
logic slow;
assign query_data = {cmd.addr, ~cmd.addr, cmd.addr ^ 8'h5a, 8'h3c};
always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        cnt <= 3'h0;
        slow <= 1'b0;
        cmd_done <= 1'b0;
    end else begin
        cmd_done <= 1'b0;
        if (cmd_valid) begin
            cnt <= slow ? 3'h4 : 3'h1;
            slow <= !slow;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            cmd_done <= cnt == 3'h1;
        end
    end
end
endmodule // urcp_rf_model
`default_nettype wire

// file: urcp_top_tb.sv
// Bench for the command port
`timescale 1ns/1ps
`default_nettype none
module urcp_top_tb;
logic core_clk, reset_n, out_ready, in_ready, cmd_valid, cmd_done;
logic resp_valid, overrun, ok;
logic [31:0] query_data, lfsr, w, d;
urcp_pkg::urcp_byte_s out_byte, in_byte;
urcp_pkg::urcp_cmd_s cmd;
int num_errors = 0;
int checks_done = 0;
urcp_top i_dut (.core_clk, .reset_n, .out_byte, .out_ready, .in_byte,
    .in_ready, .cmd, .cmd_valid, .cmd_done, .query_data, .resp_valid, .overrun);
urcp_rf_model i_rf (.core_clk, .reset_n, .cmd, .cmd_valid, .cmd_done,
    .query_data);
// ====
// Helpers
function automatic logic [31:0] rnd(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
// Reply of the register file stand-in, cut to the valid bytes
function automatic logic [31:0] reply(logic [7:0] a);
    logic [31:0] m;
    m = (a == 8'h1a) ? 32'h0000ffff : 32'hffffffff;
    return {a, ~a, a ^ 8'h5a, 8'h3c} & m;
endfunction
task automatic cmp(string s, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
        num_errors++;
        $display("unexpected %s exp %h got %h", s, e, g);
    end
endtask
task automatic close_out();
    if (num_errors == 0 && checks_done > 0) begin
        $display("TB: PASS");
    end else begin
        $display("TB: FAIL");
    end
    $finish;
endtask
task automatic put(logic [7:0] b, logic l);
    out_byte = {1'b1, l, b};
    do begin
        ok = out_ready;
        @(negedge core_clk);
    end while (!ok);
endtask
task automatic send(logic [7:0] a, int n, logic l);
    put(a, 1'b0);
    for (int i = n - 1; i >= 0; i--) begin
        put(d[8*i +: 8], l && i == 0);
    end
    out_byte = '0;
    do @(negedge core_clk); while (!out_ready);
endtask
task automatic read(int n);
    w = '0;
    while (n > 0) begin
        @(negedge core_clk);
        lfsr = rnd(lfsr);
        in_ready = lfsr[0];
        if (in_byte.valid && in_ready) begin
            cmp("last", 32'(n == 1), 32'(in_byte.last));
            w = {w[23:0], in_byte.data};
            n--;
        end
    end
    @(negedge core_clk);
    in_ready = 1'b0;
endtask
initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
end
initial begin
    #300000;
    num_errors++;
    close_out();
end
// ====
// Tests
initial begin
    logic [7:0] a;
    reset_n = 1'b0;
    out_byte = '0;
    in_ready = 1'b0;
    lfsr = 32'h5711;
    d = '0;
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    cmp("overrun", 0, overrun);
    @(negedge core_clk);
    for (int i = 0; i < 12; i++) begin
        a = (i % 6 == 5) ? 8'h05 : 8'(8'h19 + i % 6);
        lfsr = rnd(lfsr);
        d = (i == 4) ? 32'h8000_0001 : lfsr;
        send(a, a == 8'h1d ? 4 : 1, 1'b1);
        cmp("addr", a, cmd.addr);
        cmp("len", a == 8'h1d ? 4 : 1, cmd.len);
        cmp("data", a == 8'h1d ? d : d & 32'hff, cmd.data);
        if (a == 8'h05 || a == 8'h1d) begin
            cmp("idle in", 0, {resp_valid, in_byte.valid});
        end else begin
            cmp("resp up", 1, resp_valid);
            read(a == 8'h1a ? 2 : 4);
            cmp("resp", reply(a), w);
            cmp("resp done", 0, resp_valid);
        end
    end
    for (int i = 0; i < 32; i++) send(8'h05, 1, 1'b0);
    cmp("overrun", 0, overrun);
    send(8'h05, 1, 1'b1);
    cmp("overrun", 1, overrun);
    close_out();
end
endmodule // urcp_top_tb
`default_nettype wire
